// ==== ipr_pkg.sv ====
// Purpose: shared constants and types for the paged-register serial slave
// Assumes: 125 MHz core clock; timing figures given in microseconds
// Notes: the nonvolatile write and conversion times are plain defaults, not measured figures
package ipr_pkg;
    // core clock rate and long timing figures
    localparam int CLK_MHZ = 125;
    localparam int NV_WRITE_TIME_US = 10000;
    localparam int CONV_PERIOD_US = 10000;
    localparam int NV_WRITE_CYC = NV_WRITE_TIME_US * CLK_MHZ;
    localparam int CONV_CYC = CONV_PERIOD_US * CLK_MHZ;
    // fixed upper part of the 7-bit slave address; straps fill the two low bits
    localparam logic [4:0] SLV_ADDR_HI = 5'h0a;
    // memory layout
    localparam int MEM_AW = 8;
    localparam int MEM_DEPTH = 256;
    localparam int PAGE_BITS = 3;
    localparam logic [7:0] WIPER_ADDR = 8'h00;
    localparam logic [7:0] SEE_CTRL_ADDR = 8'h02;
    localparam logic [7:0] MODE_CTRL_ADDR = 8'h03;
    localparam logic [7:0] AUX_CTRL_ADDR = 8'h0a;
    localparam int SEE_BIT = 7;
    localparam int HOLD_BIT = 0;
    localparam logic [7:0] WIPER_RST = 8'h40;
    localparam logic [7:0] CTRL_RST = 8'h00;
    // bit position of the ninth (acknowledge) bit in a byte slot
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam logic [3:0] LAST_BIT = 4'h7;
    // transfer phase of the slave
    typedef enum logic [2:0] {
        PH_IDLE = 3'b000,
        PH_DEVADDR = 3'b001,
        PH_MEMADDR = 3'b010,
        PH_WDATA = 3'b011,
        PH_RDATA = 3'b100,
        PH_IGNORE = 3'b101
    } ipr_phase_t;
endpackage

// ==== ipr_bit_if.sv ====
// Purpose: carries each sampled data bit from the bus-clock domain to the core
// Assumes: bit_val stays stable for half a bus-clock period after bit_tgl flips
// Notes: bit_tgl is an event toggle; the core synchronises it before use
`timescale 1ns/1ns
interface ipr_bit_if;
    logic bit_val;
    logic bit_tgl;
    modport cap (output bit_val, output bit_tgl);
    modport core (input bit_val, input bit_tgl);
endinterface

// ==== ipr_bit_capture.sv ====
// Purpose: samples the data line on each rising edge of the bus clock
// Assumes: bus clock only toggles inside frames; no edge is needed outside them
// Notes: one flip per bit on the toggle, the value held until the next rising edge
`timescale 1ns/1ns
module ipr_bit_capture (
    // bus clock domain
    input wire logic scl_i,
    input wire logic rst_n_i,
    // data line level
    input wire logic sda_i,
    // towards the core
    ipr_bit_if.cap bit_if
);
    // receiver samples on the rising clock edge
    always_ff @(posedge scl_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bit_if.bit_val <= 1'b0;
            bit_if.bit_tgl <= 1'b0;
        end else begin
            bit_if.bit_val <= sda_i; // RULE7
            bit_if.bit_tgl <= ~bit_if.bit_tgl;
        end
    end
endmodule

// ==== ipr_timer.sv ====
// Purpose: one-shot busy window of a fixed number of core cycles
// Assumes: start is a single-cycle pulse on the core clock
// Notes: a start during a running window restarts it
`timescale 1ns/1ns
module ipr_timer #(
    parameter int CYC = 16
) (
    // core clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // control and status
    input wire logic start_i,
    output logic busy_o
);
    logic [31:0] cnt_ff;

    // count down from the loaded length
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_ff <= 32'h0;
        end else if (ce_i) begin
            if (start_i) begin
                cnt_ff <= 32'(CYC);
            end else if (cnt_ff != 32'h0) begin
                cnt_ff <= cnt_ff - 32'h1;
            end
        end
    end

    assign busy_o = (cnt_ff != 32'h0);
endmodule

// ==== ipr_i2c_slave.sv ====
// Purpose: serial slave giving byte access to a shadowed register and lookup memory
// Assumes: bus clock well below a quarter of the core clock; straps static in use
// Notes: a frozen clock enable stops the core, not the bit capture on the bus clock
// Notes on behaviour
// [RULE1] hold bit set freezes internal activity; wiper keeps its last value
// [RULE2] serial side works in standby; resume only after one full conversion period
// [RULE3] address byte is seven address bits then a direction bit; straps set two
// [RULE4] strap low gives 0, strap high gives 1; both low gives write byte 50h
// [RULE5] direction bit 0 means master writes, 1 means master reads
// [RULE6] data fall with clock high is start, rise is stop; repeated start same
// [RULE7] data changes while clock low; sample on rising edge; drive after falling
// [RULE8] eight bits msb first then ninth bit: 0 acknowledges, 1 refuses
// [RULE9] master acknowledges wanted bytes and refuses the last one before stop
// [RULE10] a foreign address makes the slave ignore the bus until next start
// [RULE11] first byte after a write header loads the address counter
// [RULE12] wiper applied on data acknowledge; nonvolatile write starts after stop
// [RULE13] a repeated start ending a write cancels the nonvolatile write
// [RULE14] one to eight data bytes per write, stored at incrementing addresses
// [RULE15] writes wrap to the start of the same eight-byte row
// [RULE16] during the nonvolatile write time the slave refuses its own address
// [RULE17] master polls the address or waits the full write time
// [RULE18] master writes the next row as a new transfer after a stop
// [RULE19] shadow-skip set means no nonvolatile write cycle and no wear
// [RULE20] a read header returns data from the current address counter
// [RULE21] write header, memory address, repeated start, read header reads there
// [RULE22] keep sending bytes while the master acknowledges
// [RULE23] shadow-skip clear writes both copies; set writes only the volatile copy
// [RULE24] hold bit is bit 0 of the volatile byte at 0Ah, resetting to 0
// [RULE25] address counter advances by one after every byte read
// [RULE26] address acknowledged again as soon as the nonvolatile write completes
`timescale 1ns/1ns
module ipr_i2c_slave #(
    parameter int NV_CYC = ipr_pkg::NV_WRITE_CYC,
    parameter int CONV_CYC_P = ipr_pkg::CONV_CYC
) (
    // core clock, reset and enable
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // serial bus; the data pin is open drain
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    // address straps
    input wire logic strap_pin_low_i,
    input wire logic strap_pin_high_i,
    // status and wiper
    output logic [7:0] wiper_o,
    output logic busy_o,
    output logic standby_o
);
    import ipr_pkg::*;

    ipr_bit_if bit_if ();
    ipr_phase_t phase_ff;
    logic [1:0] scl_sync_ff;
    logic [1:0] sda_sync_ff;
    logic [1:0] tgl_sync_ff;
    logic [1:0] strap_lo_sync_ff;
    logic [1:0] strap_hi_sync_ff;
    logic scl_d_ff;
    logic sda_d_ff;
    logic tgl_d_ff;
    logic [3:0] cnt_ff;
    logic [7:0] sh_ff;
    logic [7:0] tx_ff;
    logic [7:0] addr_ff;
    logic ack_ff;
    logic pend_ff;
    logic hold_d_ff;
    logic [7:0] mem_ff [MEM_DEPTH];
    logic start_det;
    logic stop_det;
    logic scl_fall;
    logic rx_evt;
    logic byte_done;
    logic [7:0] rx_byte;
    logic addr_match;
    logic nv_busy;
    logic conv_busy;
    logic see;
    logic hold;
    logic shadow_hit;
    logic wr_en;

    ipr_bit_capture u_cap (
        .scl_i(scl_i),
        .rst_n_i(rst_n_i),
        .sda_i(sda_i),
        .bit_if(bit_if.cap)
    );

    // pins and the bit toggle pass two flops; a third stage feeds edge detection
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scl_sync_ff <= 2'h3;
            sda_sync_ff <= 2'h3;
            tgl_sync_ff <= 2'h0;
            strap_lo_sync_ff <= 2'h0;
            strap_hi_sync_ff <= 2'h0;
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
            tgl_d_ff <= 1'b0;
        end else if (ce_i) begin
            scl_sync_ff <= {scl_sync_ff[0], scl_i};
            sda_sync_ff <= {sda_sync_ff[0], sda_i};
            tgl_sync_ff <= {tgl_sync_ff[0], bit_if.bit_tgl};
            strap_lo_sync_ff <= {strap_lo_sync_ff[0], strap_pin_low_i};
            strap_hi_sync_ff <= {strap_hi_sync_ff[0], strap_pin_high_i};
            scl_d_ff <= scl_sync_ff[1];
            sda_d_ff <= sda_sync_ff[1];
            tgl_d_ff <= tgl_sync_ff[1];
        end
    end

    // bus conditions seen in the core domain
    assign start_det = ce_i && scl_sync_ff[1] && scl_d_ff && sda_d_ff && !sda_sync_ff[1]; // RULE6
    assign stop_det = ce_i && scl_sync_ff[1] && scl_d_ff && !sda_d_ff && sda_sync_ff[1]; // RULE6
    assign scl_fall = ce_i && scl_d_ff && !scl_sync_ff[1];
    assign rx_evt = ce_i && (tgl_sync_ff[1] ^ tgl_d_ff);
    assign rx_byte = {sh_ff[6:0], bit_if.bit_val}; // RULE8
    assign byte_done = rx_evt && (cnt_ff == LAST_BIT);
    // straps fill the two low address bits; bit 0 of the byte is the direction
    assign addr_match = (rx_byte[7:1] == {SLV_ADDR_HI, strap_hi_sync_ff[1], strap_lo_sync_ff[1]}); // RULE3 RULE4
    assign see = mem_ff[SEE_CTRL_ADDR][SEE_BIT];
    assign hold = mem_ff[AUX_CTRL_ADDR][HOLD_BIT]; // RULE24
    assign shadow_hit = (addr_ff == WIPER_ADDR) || (addr_ff == MODE_CTRL_ADDR);
    assign wr_en = byte_done && (phase_ff == PH_WDATA);

    // transfer phase
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phase_ff <= PH_IDLE;
        end else if (start_det) begin
            phase_ff <= PH_DEVADDR; // RULE6
        end else if (stop_det) begin
            phase_ff <= PH_IDLE;
        end else if (byte_done) begin
            unique case (phase_ff)
                PH_DEVADDR: begin
                    // busy or foreign address: refuse and sit out until the next start
                    if (addr_match && !nv_busy) begin
                        phase_ff <= rx_byte[0] ? PH_RDATA : PH_MEMADDR; // RULE5 RULE16 RULE26
                    end else begin
                        phase_ff <= PH_IGNORE; // RULE10
                    end
                end
                PH_MEMADDR: begin
                    phase_ff <= PH_WDATA; // RULE11
                end
                default: begin
                    phase_ff <= phase_ff;
                end
            endcase
        end else if (rx_evt && cnt_ff == ACK_SLOT && phase_ff == PH_RDATA && bit_if.bit_val) begin
            phase_ff <= PH_IGNORE; // RULE9
        end
    end

    // bit count inside the nine-bit slot and the receive shifter
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_ff <= 4'h0;
            sh_ff <= 8'h00;
        end else if (start_det || stop_det) begin
            cnt_ff <= 4'h0;
        end else if (rx_evt) begin
            cnt_ff <= (cnt_ff == ACK_SLOT) ? 4'h0 : cnt_ff + 4'h1; // RULE8
            if (cnt_ff != ACK_SLOT) begin
                sh_ff <= rx_byte;
            end
        end
    end

    // acknowledge decision for the byte just received
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_ff <= 1'b0;
        end else if (start_det || stop_det) begin
            ack_ff <= 1'b0;
        end else if (byte_done) begin
            ack_ff <= (phase_ff == PH_DEVADDR && addr_match && !nv_busy)
                || phase_ff == PH_MEMADDR || phase_ff == PH_WDATA; // RULE8 RULE14
        end else if (scl_fall && cnt_ff == 4'h0) begin
            ack_ff <= 1'b0;
        end
    end

    // address counter: loaded by the memory address, wraps in row on writes
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            addr_ff <= 8'h00;
        end else if (byte_done && phase_ff == PH_MEMADDR) begin
            addr_ff <= rx_byte; // RULE11 RULE21
        end else if (wr_en) begin
            addr_ff <= {addr_ff[7:PAGE_BITS], addr_ff[PAGE_BITS-1:0] + 3'h1}; // RULE14 RULE15
        end else if (scl_fall && cnt_ff == 4'h0 && phase_ff == PH_RDATA) begin
            addr_ff <= addr_ff + 8'h1; // RULE25
        end
    end

    // byte memory; each entry reset to its power-up value
    for (genvar i = 0; i < MEM_DEPTH; i++) begin : g_mem
        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                mem_ff[i] <= (i == 0) ? WIPER_RST : CTRL_RST;
            end else if (wr_en && addr_ff == MEM_AW'(i)) begin
                mem_ff[i] <= rx_byte; // RULE14 RULE23
            end
        end
    end

    // nonvolatile write pending; a repeated start drops it, stop launches it
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pend_ff <= 1'b0;
        end else if (start_det || stop_det) begin
            pend_ff <= 1'b0; // RULE12 RULE13
        end else if (wr_en && shadow_hit && !see) begin
            pend_ff <= 1'b1; // RULE19 RULE23
        end
    end

    ipr_timer #(
        .CYC(NV_CYC)
    ) u_nv_timer (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .start_i(stop_det && pend_ff),
        .busy_o(nv_busy)
    );

    // data pin drive: ack after the eighth fall, read bits after each fall
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sda_oe_n_o <= 1'b1;
            sda_o <= 1'b0;
            tx_ff <= 8'h00;
        end else if (start_det || stop_det) begin
            sda_oe_n_o <= 1'b1;
        end else if (scl_fall) begin
            if (cnt_ff == ACK_SLOT && ack_ff) begin
                sda_oe_n_o <= 1'b0; // RULE8
            end else if (cnt_ff == 4'h0 && phase_ff == PH_RDATA) begin
                sda_oe_n_o <= mem_ff[addr_ff][7]; // RULE20 RULE22
                tx_ff <= {mem_ff[addr_ff][6:0], 1'b0};
            end else if (phase_ff == PH_RDATA && cnt_ff != ACK_SLOT) begin
                sda_oe_n_o <= tx_ff[7]; // RULE7
                tx_ff <= {tx_ff[6:0], 1'b0};
            end else begin
                sda_oe_n_o <= 1'b1;
            end
        end
    end

    // a conversion period must pass after leaving standby before the wiper moves
    ipr_timer #(
        .CYC(CONV_CYC_P)
    ) u_conv_timer (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .start_i(hold_d_ff && !hold),
        .busy_o(conv_busy)
    );

    // wiper follows the volatile copy unless held; hold_d covers the timer's start cycle
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hold_d_ff <= 1'b0;
            wiper_o <= WIPER_RST;
            busy_o <= 1'b0;
        end else if (ce_i) begin
            hold_d_ff <= hold;
            busy_o <= nv_busy;
            if (!hold && !hold_d_ff && !conv_busy) begin
                wiper_o <= mem_ff[WIPER_ADDR]; // RULE1 RULE2 RULE12
            end
        end
    end

    assign standby_o = hold_d_ff;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    // these checks take the clock enable as high; a frozen core stretches every window
    // addressing and framing
    addr_ack_a: assert property ( // RULE3 RULE4 RULE26
        byte_done && phase_ff == PH_DEVADDR && addr_match && !nv_busy
        |=> ack_ff && phase_ff != PH_IGNORE)
        else $error("own address not acknowledged");
    busy_nack_a: assert property ( // RULE16
        byte_done && phase_ff == PH_DEVADDR && nv_busy |=> !ack_ff && phase_ff == PH_IGNORE)
        else $error("address acknowledged while busy");
    foreign_addr_a: assert property ( // RULE10
        byte_done && phase_ff == PH_DEVADDR && !addr_match |=> phase_ff == PH_IGNORE && !ack_ff)
        else $error("foreign address not ignored");
    ignore_hold_a: assert property ( // RULE10
        phase_ff == PH_IGNORE && !start_det |=> (phase_ff == PH_IGNORE || phase_ff == PH_IDLE) && !ack_ff)
        else $error("ignored transfer woke before a start");
    ack_drive_a: assert property (scl_fall && cnt_ff == ACK_SLOT && ack_ff |=> !sda_oe_n_o) // RULE8
        else $error("acknowledge not driven");
    drive_low_a: assert property ($changed(sda_oe_n_o) |-> !scl_d_ff || $past(start_det || stop_det)) // RULE7
        else $error("data pin moved while clock high");

    // write path and nonvolatile window
    row_wrap_a: assert property ( // RULE15
        wr_en |=> addr_ff[7:3] == $past(addr_ff[7:3]) && addr_ff[2:0] == $past(addr_ff[2:0]) + 3'h1)
        else $error("write counter left its row");
    byte_store_a: assert property (wr_en |=> mem_ff[$past(addr_ff)] == $past(rx_byte)) // RULE14 RULE23
        else $error("written byte not stored");
    wiper_apply_a: assert property ( // RULE12
        wr_en && addr_ff == WIPER_ADDR && !hold && !hold_d_ff && !conv_busy
        |-> ##2 wiper_o == $past(rx_byte, 2))
        else $error("wiper not applied after data acknowledge");
    rep_start_a: assert property (start_det && pend_ff |=> !pend_ff ##1 !nv_busy) // RULE13
        else $error("repeated start kept nonvolatile write");
    stop_commit_a: assert property (stop_det && pend_ff |=> nv_busy [*3]) // RULE12
        else $error("stop did not launch nonvolatile write");
    skip_wear_a: assert property (wr_en && see && !start_det |=> pend_ff == $past(pend_ff)) // RULE19
        else $error("shadow-skip write scheduled nonvolatile cycle");

    // read path
    read_step_a: assert property ( // RULE25
        scl_fall && cnt_ff == 4'h0 && phase_ff == PH_RDATA && !start_det && !stop_det
        |=> addr_ff == $past(addr_ff) + 8'h1)
        else $error("read counter did not advance");
    read_drive_a: assert property ( // RULE20 RULE22
        scl_fall && cnt_ff == 4'h0 && phase_ff == PH_RDATA
        |=> sda_oe_n_o == $past(mem_ff[addr_ff][7]))
        else $error("read bit not taken from the counter location");

    // standby
    hold_freeze_a: assert property (standby_o |=> $stable(wiper_o)) // RULE1
        else $error("wiper moved in standby");
    resume_wait_a: assert property (conv_busy |=> $stable(wiper_o)) // RULE2
        else $error("wiper moved before conversion period ended");

    // main scenarios
    read_byte_c: cover property (scl_fall && cnt_ff == 4'h0 && phase_ff == PH_RDATA);
    page_write_c: cover property (wr_en && addr_ff[2:0] == 3'h7);
    busy_poll_c: cover property (byte_done && phase_ff == PH_DEVADDR && addr_match && nv_busy);
    standby_exit_c: cover property (hold_d_ff && !hold);
    ignore_restart_c: cover property (phase_ff == PH_IGNORE && start_det);
endmodule

// ==== ipr_master_model.sv ====
// Purpose: behavioural bus master that drives the paged-register slave
// Assumes: data line pulled up; bus clock period 160 ns, still between frames
// Notes: steps are offset from the core clock so bus edges never meet it
`timescale 1ns/1ns
module ipr_master_model (
    // core clock, used only to pick a phase
    input wire logic clk_i,
    // slave pin enable, active low
    input wire logic sda_oe_n_i,
    // resolved bus lines
    output logic scl_o,
    output logic sda_o
);
    logic pull_low;
    // open-drain line with pull-up: a released line reads high
    assign sda_o = (pull_low || !sda_oe_n_i) ? 1'b0 : 1'b1;
    // bus idle at time zero
    initial begin
        scl_o = 1'b1;
        pull_low = 1'b0;
    end
    // start from idle, or repeated start with the clock low
    task automatic start_c();
        if (scl_o) begin
            @(negedge clk_i);
            #3;
        end else begin
            #20 pull_low = 1'b0;
            #60 scl_o = 1'b1;
        end
        #40 pull_low = 1'b1;
        #40 scl_o = 1'b0;
    endtask
    // stop, then leave the clock standing high as bus-free time
    task automatic stop_c();
        #20 pull_low = 1'b1;
        #60 scl_o = 1'b1;
        #40 pull_low = 1'b0;
        #80;
    endtask
    // data changes only while the clock is low
    task automatic put_bit(input logic b);
        #20 pull_low = !b;
        #60 scl_o = 1'b1;
        #80 scl_o = 1'b0;
    endtask
    // release the line and sample just after the rising edge
    task automatic get_bit(output logic v);
        #20 pull_low = 1'b0;
        #60 scl_o = 1'b1;
        #10 v = sda_o;
        #70 scl_o = 1'b0;
    endtask
    // eight bits msb first, then the slave's ninth bit
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic v;
        for (int i = 7; i >= 0; i--) begin
            put_bit(b[i]);
        end
        get_bit(v);
        ack = !v;
    endtask
    // read a byte; acknowledge only when more is wanted
    task automatic recv_byte(input logic more, output logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            get_bit(b[i]);
        end
        put_bit(!more);
    endtask
endmodule

// ==== testbench.sv ====
// Purpose: self-checking bench for the paged-register serial slave
// Assumes: short busy and conversion windows keep the run brief
// Notes: bus traffic comes from the master model; each scenario judges itself
`timescale 1ns/1ns
module testbench;
    import ipr_pkg::*;
    localparam int NV = 240;
    localparam int CONV = 400;
    logic clk_i, rst_n_i, ce_i, scl, sda, sda_oe_n, strap_lo, strap_hi, busy, standby, sda_do;
    logic [7:0] wiper;
    int mismatches = 0;
    int total_checks = 0;
    int busy_cyc = 0;
    // device under test; its data output must sit low, only the enable moves the line
    ipr_i2c_slave #(.NV_CYC(NV), .CONV_CYC_P(CONV)) ipr_i2c_slave_i (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_do),
        .sda_oe_n_o(sda_oe_n), .strap_pin_low_i(strap_lo), .strap_pin_high_i(strap_hi),
        .wiper_o(wiper), .busy_o(busy), .standby_o(standby));
    // far side of the bus
    ipr_master_model ipr_master_model_i (.clk_i(clk_i), .sda_oe_n_i(sda_oe_n), .scl_o(scl), .sda_o(sda));
    // core clock
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    // total length of busy windows, in core cycles
    always @(posedge clk_i) begin
        if (busy === 1'b1)
            busy_cyc++;
    end
    // comparisons
    task automatic chk1(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // own address byte, worked out from the strap levels
    function automatic logic [7:0] dev(input logic rd);
        return {5'h0a, strap_hi, strap_lo, rd};
    endfunction
    // address byte after a start or repeated start
    task automatic hdr(input logic [7:0] b, input logic exp);
        logic a;
        ipr_master_model_i.start_c();
        ipr_master_model_i.send_byte(b, a);
        chk1(a, exp);
    endtask
    task automatic put(input logic [7:0] b);
        logic a;
        ipr_master_model_i.send_byte(b, a);
        chk1(a, 1'b1);
    endtask
    task automatic get(input logic more, input logic [7:0] exp);
        logic [7:0] d;
        ipr_master_model_i.recv_byte(more, d);
        chk8(d, exp);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        hdr(dev(1'b0), 1'b1);
        put(a);
        put(d);
        ipr_master_model_i.stop_c();
    endtask
    task automatic t_reset();
        chk8(wiper, 8'h40);
        chk1(busy, 1'b0);
        chk1(standby, 1'b0);
        chk1(sda_oe_n, 1'b1);
        chk1(sda_do, 1'b0);
    endtask
    // every strap setting; foreign address ignored until the next start
    task automatic t_straps();
        logic [7:0] d;
        logic a;
        for (int k = 0; k < 4; k++) begin
            @(negedge clk_i);
            {strap_hi, strap_lo} = 2'(k);
            repeat (5) @(negedge clk_i);
            hdr(k == 0 ? 8'h50 : dev(1'b0), 1'b1);
            hdr(dev(1'b0) ^ (8'h02 << (k % 2)), 1'b0);
            ipr_master_model_i.send_byte(dev(1'b0), a);
            chk1(a, 1'b0);
            hdr(dev(1'b1), 1'b1);
            ipr_master_model_i.recv_byte(1'b0, d);
            ipr_master_model_i.stop_c();
        end
    endtask
    // page write past the row end, then current-address and random reads
    task automatic t_page();
        hdr(dev(1'b0), 1'b1);
        put(8'h16);
        for (int i = 0; i < 5; i++)
            put(8'ha1 + 8'(i));
        ipr_master_model_i.stop_c();
        wr(8'h10, 8'ha3);
        hdr(dev(1'b0), 1'b1);
        put(8'h11);
        ipr_master_model_i.stop_c();
        hdr(dev(1'b1), 1'b1);
        get(1'b1, 8'ha4);
        get(1'b0, 8'ha5);
        ipr_master_model_i.stop_c();
        hdr(dev(1'b0), 1'b1);
        put(8'h15);
        hdr(dev(1'b1), 1'b1);
        get(1'b1, 8'h00);
        get(1'b1, 8'ha1);
        get(1'b1, 8'ha2);
        get(1'b0, 8'h00);
        ipr_master_model_i.stop_c();
    endtask
    // nonvolatile write after stop, with acknowledge polling
    task automatic t_nv_poll();
        int n0;
        int polls;
        logic a;
        n0 = busy_cyc;
        polls = 0;
        a = 1'b0;
        hdr(dev(1'b0), 1'b1);
        put(8'h00);
        put(8'h7f);
        chk8(wiper, 8'h7f);
        ipr_master_model_i.stop_c();
        chk1(busy, 1'b1);
        while (!a && polls < 10) begin
            ipr_master_model_i.start_c();
            ipr_master_model_i.send_byte(dev(1'b0), a);
            ipr_master_model_i.stop_c();
            polls++;
        end
        chk8(8'(polls), 8'h02);
        chk1(busy, 1'b0);
        chk8(8'(busy_cyc - n0), 8'(NV));
    endtask
    // repeated start ends the write: wiper moves, no busy window
    task automatic t_rstart();
        int n0;
        n0 = busy_cyc;
        hdr(dev(1'b0), 1'b1);
        put(8'h00);
        put(8'h22);
        hdr(dev(1'b0), 1'b1);
        put(8'h00);
        hdr(dev(1'b1), 1'b1);
        get(1'b0, 8'h22);
        ipr_master_model_i.stop_c();
        repeat (300) @(negedge clk_i);
        chk8(8'(busy_cyc - n0), 8'h00);
        chk8(wiper, 8'h22);
    endtask
    // shadow-skip set: volatile copy only, no busy window
    task automatic t_see();
        int n0;
        wr(8'h02, 8'h80);
        n0 = busy_cyc;
        wr(8'h00, 8'h33);
        repeat (300) @(negedge clk_i);
        chk8(8'(busy_cyc - n0), 8'h00);
        chk8(wiper, 8'h33);
        wr(8'h02, 8'h00);
    endtask
    // standby freezes the wiper; bus still served; resume after one period
    task automatic t_standby();
        wr(8'h0a, 8'h01);
        repeat (5) @(negedge clk_i);
        chk1(standby, 1'b1);
        hdr(dev(1'b0), 1'b1);
        put(8'h00);
        put(8'h55);
        hdr(dev(1'b0), 1'b1);
        put(8'h00);
        hdr(dev(1'b1), 1'b1);
        get(1'b0, 8'h55);
        ipr_master_model_i.stop_c();
        chk8(wiper, 8'h33);
        wr(8'h0a, 8'h00);
        repeat (5) @(negedge clk_i);
        chk1(standby, 1'b0);
        chk8(wiper, 8'h33);
        ce_i = 1'b0;
        repeat (CONV + 20) @(negedge clk_i);
        chk8(wiper, 8'h33);
        ce_i = 1'b1;
        repeat (CONV + 20) @(negedge clk_i);
        chk8(wiper, 8'h55);
    endtask
    // main sequence: reset for two cycles, then the scenarios
    initial begin
        rst_n_i = 1'b0;
        ce_i = 1'b1;
        strap_lo = 1'b0;
        strap_hi = 1'b0;
        repeat (2) @(negedge clk_i);
        rst_n_i = 1'b1;
        repeat (4) @(negedge clk_i);
        t_reset();
        t_straps();
        t_page();
        t_nv_poll();
        t_rstart();
        t_see();
        t_standby();
        tally_and_finish();
    end
    // watchdog: the scenarios need about two fifths of this span
    initial begin
        repeat (40000) @(posedge clk_i);
        mismatches++;
        tally_and_finish();
    end
endmodule
